// ===== inc/adc_ctrl_pkg.sv
// Constants for the converter control block: register map, fields, reset values, timing.
// Assumes a byte-wide register space reached over a 32-bit Avalon-MM slave.
package adc_ctrl_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PORT_A_PINS = 8'h05;
  localparam logic [7:0] IDX_PORT_E_PINS = 8'h09;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE = 8'h0C;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_TWO = 8'h0D;
  localparam logic [7:0] IDX_CONVERSION_RESULT = 8'h1E;
  localparam logic [7:0] IDX_CONVERTER_CONTROL = 8'h1F;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] IDX_PORT_E_DIRECTION = 8'h89;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = 8'h8C;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_TWO = 8'h8D;
  localparam logic [7:0] IDX_ANALOG_PIN_CONFIG = 8'h9F;
  localparam logic [7:0] IDX_TRIGGER_SETUP = 8'hA0;
  localparam int ADDR_W = 10;
  // Field positions
  localparam int CTL_CLK_HI = 7;
  localparam int CTL_CLK_LO = 6;
  localparam int CTL_CHAN_HI = 5;
  localparam int CTL_CHAN_LO = 3;
  localparam int CTL_GO_BIT = 2;
  localparam int CTL_PWR_BIT = 0;
  localparam int DONE_FLAG_BIT = 6;
  localparam int DONE_ENABLE_BIT = 6;
  // Write masks / reset values
  localparam logic [7:0] CTL_MASK = 8'hFD;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] PINCFG_MASK = 8'h07;
  localparam logic [7:0] PINCFG_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] TWO_MASK = 8'h01;
  localparam logic [7:0] PORT_A_MASK = 8'h3F;
  localparam logic [7:0] PORT_E_MASK = 8'h07;
  localparam logic [7:0] DIR_A_RESET = 8'h3F;
  localparam logic [7:0] DIR_E_RESET = 8'h07;
  localparam logic [7:0] DIR_E_MASK = 8'hF7;
  localparam logic [3:0] TRIGGER_MODE = 4'hB;
  localparam logic [1:0] CLK_SEL_RC = 2'h3;
  // Timing: conversion bit periods, in clock cycles per divider setting
  localparam int CONV_BITS_X2 = 18;
  localparam int ABORT_WAIT_BITS = 2;
  localparam int CLK_SYS_MHZ = 250;
  localparam int RC_PERIOD_NS = 4000;
  localparam int RC_CYCLES = (RC_PERIOD_NS * CLK_SYS_MHZ) / 1000;
  localparam logic [11:0] DIV_2 = 12'd2;
  localparam logic [11:0] DIV_8 = 12'd8;
  localparam logic [11:0] DIV_32 = 12'd32;
  localparam logic [11:0] DIV_RC = 12'(RC_CYCLES);
endpackage : adc_ctrl_pkg

// ===== src/adc_bit_clock.sv
// Conversion half-bit-period tick generator.
// Assumes clk_sys runs at the rate named in the package; ticks only when enabled.
`timescale 1ns/1ps
module adc_bit_clock
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [1:0] clk_select,
  // Half-period tick
  output logic half_tick
);
  logic [11:0] count;
  logic [11:0] next_count;
  logic next_half_tick;
  logic [11:0] limit;

  // Half a bit period per tick so that 9.0 periods are counted in halves
  function automatic logic [11:0] half_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: half_of = DIV_2 >> 1;
      2'h1: half_of = DIV_8 >> 1;
      2'h2: half_of = DIV_32 >> 1;
      2'h3: half_of = DIV_RC >> 1;
    endcase
  endfunction : half_of

  always_comb begin
    limit = half_of(clk_select);
    next_count = 12'h000;
    next_half_tick = 1'b0;
    if (run) begin
      if (count + 12'h001 >= limit) begin
        next_half_tick = 1'b1;
      end else begin
        next_count = count + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= 12'h000;
      half_tick <= 1'b0;
    end else begin
      count <= next_count;
      half_tick <= next_half_tick;
    end
  end
endmodule : adc_bit_clock

// ===== src/adc_result_store.sv
// Holds the conversion result byte; read data come out of a register.
// Assumes one writer per cycle; conversion load has priority over software.
`timescale 1ns/1ps
module adc_result_store #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Writes
  input wire logic load_conv,
  input wire logic [WIDTH-1:0] conv_data,
  input wire logic load_sw,
  input wire logic [WIDTH-1:0] sw_data,
  // Read
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] next_value;

  always_comb begin
    next_value = value;
    if (load_conv) begin
      next_value = conv_data;
    end else if (load_sw) begin
      next_value = sw_data;
    end
  end

  // No reset on the content: it is undefined until first written [RL5]
  always_ff @(posedge clk_sys) begin
    value <= next_value;
  end
endmodule : adc_result_store

// ===== src/adc_reset_and_trigger_control.sv
// Converter control: register file, conversion sequencer, special event trigger.
// Assumes a 32-bit Avalon-MM master, an external sample-and-compare engine that
// supplies the converted byte, and a capture/compare unit giving a one-cycle trigger.
`timescale 1ns/1ps

// Contract
// [RL1] Sleep conversion needs RC clock, halt next
// [RL2] Device reset forces all registers to reset; the result store here has no reset
// [RL3] Reset disables converter and aborts conversion
// [RL4] After reset all converter pins analog
// [RL5] Result register not initialised by reset
// [RL6] Trigger accepted only with mode 1011, powered
// [RL7] Accepted trigger sets go and clears timer
// [RL8] Software selects channel, waits acquisition first
// [RL9] Unpowered converter ignores trigger; timer still clears
// [RL10] Control register layout and reset value
// [RL11] Pin configuration register: three bits, reset zero
// [RL12] Done flag at bit 6 of flags one
// [RL13] Done enable at bit 6 of enables one
// [RL14] Unimplemented bits read as zero
// [RL15] Software keeps parallel-port bits clear
// [RL16] Clearing go aborts, result kept
// [RL17] Conversion lasts nine bit periods
// [RL18] After abort wait two periods, reacquire
// [RL19] Completion loads result, clears go, sets flag
// [RL20] Trigger during conversion is ignored
module adc_reset_and_trigger_control
  import adc_ctrl_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Capture/compare trigger and converted sample
  input wire logic special_event_trigger,
  input wire logic [DATA_W-1:0] sample_data,
  // Converter and timer side
  output logic timer_clear,
  output logic converting,
  output logic acquiring,
  output logic [2:0] input_channel_select,
  output logic [2:0] pin_analog_setting,
  output logic conversion_done_irq
);
  import adc_ctrl_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b10
  } seq_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] converter_control;
  logic [7:0] analog_pin_config;
  logic [7:0] peripheral_flags_one;
  logic [7:0] peripheral_flags_two;
  logic [7:0] peripheral_enables_one;
  logic [7:0] peripheral_enables_two;
  logic [7:0] interrupt_control;
  logic [7:0] port_a_pins;
  logic [7:0] port_e_pins;
  logic [7:0] port_a_direction;
  logic [7:0] port_e_direction;
  logic [3:0] second_unit_mode_field;
  logic [7:0] next_converter_control;
  logic [7:0] next_analog_pin_config;
  logic [7:0] next_peripheral_flags_one;
  logic [7:0] next_peripheral_flags_two;
  logic [7:0] next_peripheral_enables_one;
  logic [7:0] next_peripheral_enables_two;
  logic [7:0] next_interrupt_control;
  logic [7:0] next_port_a_pins;
  logic [7:0] next_port_e_pins;
  logic [7:0] next_port_a_direction;
  logic [7:0] next_port_e_direction;
  logic [3:0] next_second_unit_mode_field;

  // Bus state
  logic [31:0] next_avs_readdata;
  logic next_avs_waitrequest;
  logic [1:0] next_avs_response;
  logic bus_active;
  logic [7:0] wbyte;
  logic [7:0] index;
  logic wr_hit;
  logic mapped;

  // Sequencer state
  seq_e state;
  seq_e next_state;
  logic [4:0] halves;
  logic [4:0] next_halves;
  logic half_tick;
  logic done_now;
  logic trig_ok;
  logic [7:0] result_value;
  logic sw_result_load;
  logic next_timer_clear;
  logic next_converting;
  logic next_acquiring;
  logic next_irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] read_reg(input logic [7:0] idx);
    read_reg = 8'h00;
    unique case (idx)
      IDX_CONVERTER_CONTROL: read_reg = converter_control & CTL_MASK; // [RL10] [RL14]
      IDX_ANALOG_PIN_CONFIG: read_reg = analog_pin_config & PINCFG_MASK; // [RL11] [RL14]
      IDX_PERIPHERAL_FLAGS_ONE: read_reg = peripheral_flags_one; // [RL12]
      IDX_PERIPHERAL_FLAGS_TWO: read_reg = peripheral_flags_two & TWO_MASK;
      IDX_PERIPHERAL_ENABLES_ONE: read_reg = peripheral_enables_one; // [RL13]
      IDX_PERIPHERAL_ENABLES_TWO: read_reg = peripheral_enables_two & TWO_MASK;
      IDX_INTERRUPT_CONTROL: read_reg = interrupt_control;
      IDX_CONVERSION_RESULT: read_reg = result_value;
      // Analog-configured port pins read low; not modelled, the written latch is read back masked to the port width
      IDX_PORT_A_PINS: read_reg = port_a_pins & PORT_A_MASK;
      IDX_PORT_E_PINS: read_reg = port_e_pins & PORT_E_MASK;
      IDX_PORT_A_DIRECTION: read_reg = port_a_direction & PORT_A_MASK;
      IDX_PORT_E_DIRECTION: read_reg = port_e_direction & DIR_E_MASK;
      IDX_TRIGGER_SETUP: read_reg = {4'h0, second_unit_mode_field};
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = idx inside {IDX_CONVERTER_CONTROL, IDX_ANALOG_PIN_CONFIG,
      IDX_PERIPHERAL_FLAGS_ONE, IDX_PERIPHERAL_FLAGS_TWO, IDX_PERIPHERAL_ENABLES_ONE,
      IDX_PERIPHERAL_ENABLES_TWO, IDX_INTERRUPT_CONTROL, IDX_CONVERSION_RESULT,
      IDX_PORT_A_PINS, IDX_PORT_E_PINS, IDX_PORT_A_DIRECTION, IDX_PORT_E_DIRECTION,
      IDX_TRIGGER_SETUP};
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  adc_bit_clock u_bit_clock (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(state != ST_IDLE),
    .clk_select(converter_control[CTL_CLK_HI:CTL_CLK_LO]),
    .half_tick(half_tick)
  );

  adc_result_store #(.WIDTH(8)) u_result (
    .clk_sys(clk_sys),
    .rst(rst),
    .load_conv(done_now),
    .conv_data(sample_data),
    .load_sw(sw_result_load),
    .sw_data(wbyte),
    .value(result_value)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode: every access answered one cycle after it is seen
  always_comb begin
    index = avs_address[ADDR_W-1:2];
    wbyte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    mapped = is_mapped(index);
    bus_active = (avs_read || avs_write) && avs_waitrequest;
    wr_hit = bus_active && avs_write && avs_byteenable[0];
    sw_result_load = wr_hit && (index == IDX_CONVERSION_RESULT);
    next_avs_waitrequest = ~bus_active;
    next_avs_readdata = 32'h0000_0000;
    next_avs_response = 2'h0;
    if (bus_active) begin
      next_avs_response = mapped ? 2'h0 : 2'h2;
      if (avs_read) begin
        next_avs_readdata = {24'h000000, read_reg(index)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and register next values
  always_comb begin
    next_converter_control = converter_control;
    next_analog_pin_config = analog_pin_config;
    next_peripheral_flags_one = peripheral_flags_one;
    next_peripheral_flags_two = peripheral_flags_two;
    next_peripheral_enables_one = peripheral_enables_one;
    next_peripheral_enables_two = peripheral_enables_two;
    next_interrupt_control = interrupt_control;
    next_port_a_pins = port_a_pins;
    next_port_e_pins = port_e_pins;
    next_port_a_direction = port_a_direction;
    next_port_e_direction = port_e_direction;
    next_second_unit_mode_field = second_unit_mode_field;
    next_state = state;
    next_halves = halves;
    done_now = 1'b0;

    // Software writes
    if (wr_hit) begin
      unique case (index)
        IDX_CONVERTER_CONTROL: next_converter_control = wbyte & CTL_MASK; // [RL10]
        IDX_ANALOG_PIN_CONFIG: next_analog_pin_config = wbyte & PINCFG_MASK; // [RL11]
        IDX_PERIPHERAL_FLAGS_ONE: next_peripheral_flags_one = wbyte;
        IDX_PERIPHERAL_FLAGS_TWO: next_peripheral_flags_two = wbyte & TWO_MASK;
        IDX_PERIPHERAL_ENABLES_ONE: next_peripheral_enables_one = wbyte;
        IDX_PERIPHERAL_ENABLES_TWO: next_peripheral_enables_two = wbyte & TWO_MASK;
        IDX_INTERRUPT_CONTROL: next_interrupt_control = wbyte;
        IDX_PORT_A_PINS: next_port_a_pins = wbyte & PORT_A_MASK;
        IDX_PORT_E_PINS: next_port_e_pins = wbyte & PORT_E_MASK;
        IDX_PORT_A_DIRECTION: next_port_a_direction = wbyte & PORT_A_MASK;
        IDX_PORT_E_DIRECTION: next_port_e_direction = wbyte & DIR_E_MASK;
        IDX_TRIGGER_SETUP: next_second_unit_mode_field = wbyte[3:0];
        default: ;
      endcase
    end

    // Trigger: mode must match and converter powered; ignored mid-conversion
    trig_ok = special_event_trigger && (second_unit_mode_field == TRIGGER_MODE)
              && next_converter_control[CTL_PWR_BIT] && (state == ST_IDLE); // [RL6] [RL9] [RL20]
    if (trig_ok) begin
      next_converter_control[CTL_GO_BIT] = 1'b1; // [RL7]
    end

    unique case (state)
      ST_IDLE: begin
        next_halves = 5'h00;
        if (next_converter_control[CTL_GO_BIT] && next_converter_control[CTL_PWR_BIT]) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (!next_converter_control[CTL_GO_BIT] || !next_converter_control[CTL_PWR_BIT]) begin
          next_state = ST_WAIT; // [RL16]
          next_halves = 5'h00;
          next_converter_control[CTL_GO_BIT] = 1'b0;
        end else if (half_tick) begin
          if (halves == 5'(CONV_BITS_X2 - 1)) begin
            done_now = 1'b1; // [RL17]
            next_converter_control[CTL_GO_BIT] = 1'b0; // [RL19]
            next_state = ST_IDLE;
          end else begin
            next_halves = halves + 5'h01;
          end
        end
      end
      ST_WAIT: begin
        // Go is held low until the two-period recovery has passed
        next_converter_control[CTL_GO_BIT] = 1'b0;
        if (half_tick) begin
          if (halves == 5'(2 * ABORT_WAIT_BITS - 1)) begin
            next_state = ST_IDLE; // [RL18]
          end else begin
            next_halves = halves + 5'h01;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase

    // Hardware set wins over software clear
    if (done_now) begin
      next_peripheral_flags_one[DONE_FLAG_BIT] = 1'b1; // [RL19] [RL12]
    end

    next_timer_clear = special_event_trigger && (second_unit_mode_field == TRIGGER_MODE); // [RL7] [RL9]
    next_converting = (next_state == ST_CONV);
    next_acquiring = (next_state == ST_IDLE) && next_converter_control[CTL_PWR_BIT]; // [RL18]
    next_irq = next_peripheral_flags_one[DONE_FLAG_BIT]
               && next_peripheral_enables_one[DONE_ENABLE_BIT]; // [RL13]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      converter_control <= CTL_RESET; // [RL2] [RL3] [RL10]
      analog_pin_config <= PINCFG_RESET; // [RL4] [RL11]
      peripheral_flags_one <= FLAGS_RESET; // [RL12]
      peripheral_flags_two <= FLAGS_RESET;
      peripheral_enables_one <= ENABLES_RESET; // [RL13]
      peripheral_enables_two <= ENABLES_RESET;
      interrupt_control <= 8'h00;
      port_a_pins <= 8'h00;
      port_e_pins <= 8'h00;
      port_a_direction <= DIR_A_RESET; // [RL4]
      port_e_direction <= DIR_E_RESET;
      second_unit_mode_field <= 4'h0;
      state <= ST_IDLE; // [RL3]
      halves <= 5'h00;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      avs_response <= 2'h0;
      timer_clear <= 1'b0;
      converting <= 1'b0;
      acquiring <= 1'b0;
      input_channel_select <= 3'h0;
      pin_analog_setting <= 3'h0;
      conversion_done_irq <= 1'b0;
    end else begin
      converter_control <= next_converter_control;
      analog_pin_config <= next_analog_pin_config;
      peripheral_flags_one <= next_peripheral_flags_one;
      peripheral_flags_two <= next_peripheral_flags_two;
      peripheral_enables_one <= next_peripheral_enables_one;
      peripheral_enables_two <= next_peripheral_enables_two;
      interrupt_control <= next_interrupt_control;
      port_a_pins <= next_port_a_pins;
      port_e_pins <= next_port_e_pins;
      port_a_direction <= next_port_a_direction;
      port_e_direction <= next_port_e_direction;
      second_unit_mode_field <= next_second_unit_mode_field;
      state <= next_state;
      halves <= next_halves;
      avs_readdata <= next_avs_readdata;
      avs_waitrequest <= next_avs_waitrequest;
      avs_response <= next_avs_response;
      timer_clear <= next_timer_clear;
      converting <= next_converting;
      acquiring <= next_acquiring;
      input_channel_select <= next_converter_control[CTL_CHAN_HI:CTL_CHAN_LO];
      pin_analog_setting <= next_analog_pin_config[2:0];
      conversion_done_irq <= next_irq;
    end
  end
endmodule : adc_reset_and_trigger_control

// ===== verification/adc_ctrl_props.sv
// Checker for the converter control block: bus answer, trigger and conversion timing.
// Sees only top-level ports; bound to every instance of the block.
`timescale 1ns/1ps
module adc_ctrl_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Converter side
  input wire logic special_event_trigger,
  input wire logic timer_clear,
  input wire logic converting,
  input wire logic acquiring,
  input wire logic [2:0] input_channel_select,
  input wire logic [2:0] pin_analog_setting,
  input wire logic conversion_done_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles spent converting; the slowest clock choice bounds it
  logic [15:0] conv_cnt;
  logic [15:0] next_conv_cnt;
  always_comb next_conv_cnt = converting ? conv_cnt + 16'h1 : 16'h0;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) conv_cnt <= 16'h0;
    else conv_cnt <= next_conv_cnt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_ANSWER_NEXT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in the next cycle");
  AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held longer than one cycle");
  AST_HIGH_BYTES_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  AST_CLEAR_CAUSE: assert property (timer_clear |-> $past(special_event_trigger))
    else $error("timer clear without a trigger");
  AST_TRIGGER_STARTS: assert property (special_event_trigger && acquiring && !avs_write ##1 timer_clear |=> converting)
    else $error("accepted trigger did not start a conversion");
  AST_UNPOWERED_IGNORED: assert property (special_event_trigger && !acquiring && !converting && !avs_write |=> !converting [*2])
    else $error("trigger started a conversion while off");
  AST_NOT_BOTH: assert property (!(converting && acquiring))
    else $error("converting and acquiring together");
  AST_CONV_MAX: assert property (conv_cnt <= 16'h46B4)
    else $error("conversion ran too long");
  AST_RESET_STATE: assert property ($fell(rst) |-> !converting && !acquiring && pin_analog_setting == 3'h0 && input_channel_select == 3'h0)
    else $error("outputs not in reset state after reset");
  AST_IRQ_CAUSE: assert property ($rose(conversion_done_irq) |-> $past(converting) || $past(converting, 2) || $past(avs_write))
    else $error("interrupt rose without completion or write");
  ////////////////////////////////////////////////////////////////////////////////
  cover property (timer_clear);
  cover property ($fell(converting));
  cover property (!avs_waitrequest && avs_response == 2'h2);
endmodule : adc_ctrl_props

bind adc_reset_and_trigger_control adc_ctrl_props i_props (
  .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .special_event_trigger(special_event_trigger), .timer_clear(timer_clear),
  .converting(converting), .acquiring(acquiring), .input_channel_select(input_channel_select),
  .pin_analog_setting(pin_analog_setting), .conversion_done_irq(conversion_done_irq)
);

// ===== verification/adc_front_model.sv
// Far-side model: capture/compare trigger source and analog sample engine.
// Assumes the bench asks for a trigger with a one-cycle fire pulse.
`timescale 1ns/1ps
module adc_front_model (
  // Clock
  input wire logic clk_sys,
  // Bench control
  input wire logic fire,
  input wire logic [7:0] level,
  // Converter side
  input wire logic converting,
  output logic special_event_trigger = 1'b0,
  output logic [7:0] sample_data
);
  always_ff @(posedge clk_sys) special_event_trigger <= fire;
  // Sample is only held while converting; the inverse shows a stale load
  assign sample_data = converting ? level : ~level;
endmodule : adc_front_model

// ===== verification/tb_adc_reset_and_trigger_control.sv
// Testbench for the converter control block: register map, trigger, conversion timing.
// Assumes the far-side model in adc_front_model and a 250 MHz system clock.
`timescale 1ns/1ps
module tb_adc_reset_and_trigger_control;
  import adc_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, special_event_trigger, timer_clear, converting, acquiring, tc;
  logic [1:0] avs_response, last_resp;
  logic [7:0] sample_data;
  logic [2:0] input_channel_select, pin_analog_setting;
  logic conversion_done_irq;
  logic fire = 1'b0;
  logic [7:0] level = 8'h00;
  int errors = 0;
  int checks = 0;
  int n, len;
  logic [7:0] ridx [8] = '{8'h1F, 8'h9F, 8'h0C, 8'h0D, 8'h8C, 8'h8D, 8'h85, 8'h89};
  logic [7:0] rval [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h07};
  // Clocks per half bit period, per clock select
  int half [4] = '{1, 4, 16, 500};
  always #2 clk_sys = ~clk_sys;
  adc_reset_and_trigger_control i_dut (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .special_event_trigger(special_event_trigger), .sample_data(sample_data),
    .timer_clear(timer_clear), .converting(converting), .acquiring(acquiring),
    .input_channel_select(input_channel_select), .pin_analog_setting(pin_analog_setting),
    .conversion_done_irq(conversion_done_irq)
  );
  adc_front_model i_front (
    .clk_sys(clk_sys), .fire(fire), .level(level), .converting(converting),
    .special_event_trigger(special_event_trigger), .sample_data(sample_data)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) errors++;
    q = avs_readdata;
    last_resp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    bus(1'b0, idx, 8'h00);
    chk(nm, {24'h0, exp}, q);
  endtask : rd
  // One trigger pulse; notes whether the timer clear followed
  task automatic trig();
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    tc = 1'b0;
    repeat (4) begin
      @(posedge clk_sys);
      if (timer_clear === 1'b1) tc = 1'b1;
    end
  endtask : trig
  task automatic conv_len();
    len = 0;
    n = 0;
    while (converting !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    while (converting === 1'b1 && len < 20000) begin
      @(posedge clk_sys);
      len++;
    end
  endtask : conv_len
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(4 * 80000);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(ridx[i], rval[i], "reset value");
    chk("pin setting", 3'h0, pin_analog_setting);
    $display("test reset values done");
    bus(1'b1, IDX_CONVERTER_CONTROL, 8'hC3);
    rd(IDX_CONVERTER_CONTROL, 8'hC1, "control");
    bus(1'b1, IDX_ANALOG_PIN_CONFIG, 8'hFF);
    rd(IDX_ANALOG_PIN_CONFIG, 8'h07, "pin config");
    chk("pin setting", 3'h7, pin_analog_setting);
    bus(1'b1, 8'h40, 8'h55);
    chk("unmapped response", 2'h2, last_resp);
    rd(8'h40, 8'h00, "unmapped read");
    $display("test register access done");
    bus(1'b1, IDX_CONVERTER_CONTROL, 8'h29);
    chk("channel", 3'h5, input_channel_select);
    trig();
    chk("clear, mode off", 1'b0, tc);
    chk("start, mode off", 1'b0, converting);
    bus(1'b1, IDX_TRIGGER_SETUP, 8'h0B);
    bus(1'b1, IDX_CONVERTER_CONTROL, 8'h28);
    trig();
    chk("clear, unpowered", 1'b1, tc);
    chk("start, unpowered", 1'b0, converting);
    bus(1'b1, IDX_PERIPHERAL_ENABLES_ONE, 8'h40);
    bus(1'b1, IDX_CONVERTER_CONTROL, 8'h29);
    repeat (20) @(posedge clk_sys);
    level <= 8'hA5;
    trig();
    chk("clear, accepted", 1'b1, tc);
    chk("start, accepted", 1'b1, converting);
    trig();
    chk("clear, busy", 1'b1, tc);
    conv_len();
    chk("no restart", 1'b1, len < 14);
    rd(IDX_CONVERSION_RESULT, 8'hA5, "result");
    rd(IDX_CONVERTER_CONTROL, 8'h29, "go cleared");
    rd(IDX_PERIPHERAL_FLAGS_ONE, 8'h40, "done flag");
    chk("interrupt", 1'b1, conversion_done_irq);
    $display("test trigger done");
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, IDX_CONVERTER_CONTROL, {s[1:0], 6'h2D});
      conv_len();
      chk("length", 1'b1, len >= 18 * half[s] && len <= 18 * half[s] + 4);
    end
    $display("test conversion clocks done");
    level <= 8'h3C;
    bus(1'b1, IDX_CONVERTER_CONTROL, 8'h2D);
    repeat (10) @(posedge clk_sys);
    bus(1'b1, IDX_CONVERTER_CONTROL, 8'h29);
    n = 0;
    while (acquiring !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    chk("abort wait", 1'b1, n >= 3 && n <= 6);
    rd(IDX_CONVERSION_RESULT, 8'hA5, "result kept");
    $display("test abort done");
    bus(1'b1, IDX_CONVERTER_CONTROL, 8'h2D);
    repeat (5) @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    chk("converting in reset", 1'b0, converting);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(IDX_CONVERTER_CONTROL, 8'h00, "control after reset");
    rd(IDX_ANALOG_PIN_CONFIG, 8'h00, "pin config after reset");
    rd(IDX_CONVERSION_RESULT, 8'hA5, "result after reset");
    $display("test reset mid-conversion done");
    end_of_test();
  end
endmodule : tb_adc_reset_and_trigger_control
